// file: hw/scr_pkg.sv
/*
 * Shared constants and types for the serial configuration read-out block.
 * Assumes a single 50 MHz system clock; no other package is needed.
 */
package scr_pkg;

  // ------------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          WORD_W        = 8;
  localparam int          FIFO_DEPTH    = 32;
  localparam logic [11:0] ADDR_RESET    = 12'h000;
  localparam logic [11:0] LAST_ADDR_DEF = 12'hfff;
  localparam logic        POL_DEF       = 1'b1;

  // ------------------------------------------------------------------
  // power-on reset timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int POR_TIME_US  = 100;
  localparam int POR_CYCLES   = POR_TIME_US * CLK_MHZ;
  localparam int POR_W        = 14;

  // ------------------------------------------------------------------
  // read-out phases
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCR_POWER_UP,
    SCR_IDLE,
    SCR_STREAM,
    SCR_DONE
  } scr_phase_type;

endpackage : scr_pkg

// file: hw/scr_fifo_if.sv
/*
 * Carrier for the word stream between memory fetch and the bit shifter.
 * Assumes both ends run on the block's single clock.
 */
`timescale 1ns/1ns
interface scr_fifo_if #(
  parameter int WIDTH = 8
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic             flush;

  modport fifo
  (
    input  in_valid, in_data, out_ready, flush,
    output in_ready, out_valid, out_data
  );
  modport user
  (
    output in_valid, in_data, out_ready, flush,
    input  in_ready, out_valid, out_data
  );
endinterface : scr_fifo_if

// file: hw/scr_fifo.sv
/*
 * Word FIFO with registered read data, valid/ready on both sides.
 * Assumes one clock, synchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ns
module scr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // stream
  scr_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic             dv_r, dv_nxt;
  logic             push, pop, load;

  assign f.in_ready  = (cnt_r != (AW+1)'(DEPTH)) && !f.flush;
  assign f.out_valid = dv_r;
  assign f.out_data  = dout_r;

  always_comb
  begin
    push     = f.in_valid && f.in_ready;
    load     = (cnt_r != '0) && (!dv_r || f.out_ready);
    pop      = load;
    wr_nxt   = push ? wr_r + 1'b1 : wr_r;
    rd_nxt   = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    dout_nxt = load ? mem[rd_r] : dout_r;
    dv_nxt   = load ? 1'b1 : (f.out_ready ? 1'b0 : dv_r);
    if (f.flush)
    begin
      wr_nxt  = '0;
      rd_nxt  = '0;
      cnt_nxt = '0;
      dv_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_r   <= '0;
      rd_r   <= '0;
      cnt_r  <= '0;
      dv_r   <= 1'b0;
      dout_r <= '0;
    end
    else if (ce)
    begin
      wr_r   <= wr_nxt;
      rd_r   <= rd_nxt;
      cnt_r  <= cnt_nxt;
      dv_r   <= dv_nxt;
      dout_r <= dout_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem[wr_r] <= f.in_data;
    end
  end

endmodule : scr_fifo

// file: hw/scr_readout.sv
/*
 * Read-out side of a serial configuration memory: words from the stored
 * array pass a FIFO and are shifted out MSB first, one bit per rising
 * shift clock edge, gated by chip select and reset/output-enable.
 * Assumes the link pins and data_in are asynchronous to clk and are synchronised here; the
 * array contents are a read port supplied by the surrounding chip, data
 * one cycle after address.
 */
// Notes on behaviour
// - reset level clears counter, floats data
// - reset/enable and select gate everything
// - select high after reset: halted, floating
// - select low enables counter and data
// - reset clears regardless of chip select
// - finished memory keeps data floating
// - power-up clears counter without pin reset
// - edge after last bit: cascade low
// - next memory continues on low select
// - reset pin polarity is programmable
// - program enable low leaves read-out
// - select high means standby, floating
// - rising clock advances only when enabled
// - reset with select low: chain master
// - ready held low during power-on
`timescale 1ns/1ns
module scr_readout #(
  parameter int          ADDR_W     = scr_pkg::ADDR_W,
  parameter int          WORD_W     = scr_pkg::WORD_W,
  parameter int          FIFO_DEPTH = scr_pkg::FIFO_DEPTH,
  parameter int          POR_CYCLES = scr_pkg::POR_CYCLES,
  parameter logic [ADDR_W-1:0] LAST_ADDR = scr_pkg::LAST_ADDR_DEF
)
(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  // link pins
  input  wire logic              shift_clock,
  input  wire logic              reset_oe,
  input  wire logic              chip_select_n,
  input  wire logic              serial_program_enable_n,
  // programmed setting: 1 = reset low / enable high
  input  wire logic              reset_pol_high_en,
  // serial data pin
  input  wire logic              data_in,
  output logic                   data_out,
  output logic                   data_oe,
  // cascade output
  output logic                   chain_next_select_n,
  // open-drain ready indicator
  output logic                   ready_out,
  output logic                   ready_oe,
  // stored array read port
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_rd,
  input  wire logic [WORD_W-1:0] mem_data,
  // status
  output logic                   program_mode,
  output logic                   chain_master
);
  localparam int BW = $clog2(WORD_W);
  localparam int POR_W = scr_pkg::POR_W;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [4:0] s1_r, s2_r;
  logic       sclk_d_r;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_r     <= 5'h1c;
      s2_r     <= 5'h1c;
      sclk_d_r <= 1'b0;
    end
    else if (ce)
    begin
      s1_r     <= {serial_program_enable_n, chip_select_n, reset_oe,
                   shift_clock, data_in};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[1];
    end
  end

  logic prog_n_s, cs_n_s, roe_s, sclk_s, sclk_rise;
  assign prog_n_s  = s2_r[4];
  assign cs_n_s    = s2_r[3];
  assign roe_s     = s2_r[2];
  assign sclk_s    = s2_r[1];
  assign sclk_rise = sclk_s && !sclk_d_r;

  // ------------------------------------------------------------------
  // gating terms
  // ------------------------------------------------------------------
  logic in_reset, enabled, readout_mode;
  assign in_reset     = (roe_s != reset_pol_high_en);
  assign readout_mode = prog_n_s;
  assign enabled = readout_mode && !in_reset && !cs_n_s;

  // ------------------------------------------------------------------
  // word stream carrier and FIFO
  // ------------------------------------------------------------------
  scr_fifo_if #(.WIDTH(WORD_W)) fq ();

  scr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .f     (fq)
  );

  // ------------------------------------------------------------------
  // phase, counters and shifter
  // ------------------------------------------------------------------
  scr_pkg::scr_phase_type phase_r, phase_nxt;
  logic [POR_W-1:0]  por_r, por_nxt;
  logic [ADDR_W-1:0] fetch_r, fetch_nxt;
  logic [ADDR_W-1:0] out_addr_r, out_addr_nxt;
  logic              vld_r;
  logic              fetch_done_r, fetch_done_nxt;
  logic              rd_pend_r, rd_pend_nxt;
  logic [WORD_W-1:0] sh_r, sh_nxt;
  logic [BW-1:0]     bit_r, bit_nxt;
  logic              sh_valid_r, sh_valid_nxt;
  logic              last_word_r, last_word_nxt;
  logic              dout_r, dout_nxt;
  logic              doe_r, doe_nxt;
  logic              casc_n_r, casc_n_nxt;
  logic              rdy_oe_r, rdy_oe_nxt;
  logic              master_r, master_nxt;
  logic              prog_r, prog_nxt;
  logic              in_reset_d_r, in_reset_d_nxt;
  logic              clear;

  always_comb
  begin
    phase_nxt      = phase_r;
    por_nxt        = por_r;
    fetch_nxt      = fetch_r;
    out_addr_nxt   = out_addr_r;
    fetch_done_nxt = fetch_done_r;
    rd_pend_nxt    = 1'b0;
    sh_nxt         = sh_r;
    bit_nxt        = bit_r;
    sh_valid_nxt   = sh_valid_r;
    last_word_nxt  = last_word_r;
    dout_nxt       = dout_r;
    doe_nxt        = 1'b0;
    casc_n_nxt     = casc_n_r;
    rdy_oe_nxt     = rdy_oe_r;
    master_nxt     = master_r;
    prog_nxt       = !readout_mode;
    in_reset_d_nxt = in_reset;
    clear          = 1'b0;
    fq.in_valid    = vld_r;
    fq.in_data     = mem_data;
    fq.out_ready   = 1'b0;
    fq.flush       = 1'b0;

    unique case (phase_r)
      scr_pkg::SCR_POWER_UP:
      begin
        clear      = 1'b1;
        rdy_oe_nxt = 1'b1;
        if (por_r == POR_W'(POR_CYCLES - 1))
        begin
          rdy_oe_nxt = 1'b0;
          phase_nxt  = scr_pkg::SCR_IDLE;
        end
        else
        begin
          por_nxt = por_r + 1'b1;
        end
      end
      scr_pkg::SCR_IDLE, scr_pkg::SCR_STREAM, scr_pkg::SCR_DONE:
      begin
        if (in_reset || !readout_mode)
        begin
          clear     = 1'b1;
          phase_nxt = scr_pkg::SCR_IDLE;
        end
        else if (phase_r == scr_pkg::SCR_IDLE)
        begin
          phase_nxt = scr_pkg::SCR_STREAM;
        end
      end
    endcase

    if (in_reset && !in_reset_d_r)
    begin
      master_nxt = !cs_n_s;
    end

    if (clear)
    begin
      fetch_nxt      = scr_pkg::ADDR_RESET;
      out_addr_nxt   = scr_pkg::ADDR_RESET;
      fetch_done_nxt = 1'b0;
      sh_valid_nxt   = 1'b0;
      last_word_nxt  = 1'b0;
      bit_nxt        = '0;
      casc_n_nxt     = 1'b1;
      fq.flush       = 1'b1;
      fq.in_valid    = 1'b0;
    end
    else if (phase_r == scr_pkg::SCR_STREAM)
    begin
      // prefetch keeps the FIFO topped up while words remain
      // one read in flight at a time, so a full FIFO never drops a word
      if (!fetch_done_r && fq.in_ready && !rd_pend_r && !vld_r)
      begin
        rd_pend_nxt = 1'b1;
        if (fetch_r == LAST_ADDR)
        begin
          fetch_done_nxt = 1'b1;
        end
        else
        begin
          fetch_nxt = fetch_r + 1'b1;
        end
      end
      if (!sh_valid_r && fq.out_valid)
      begin
        fq.out_ready  = 1'b1;
        sh_nxt        = fq.out_data;
        sh_valid_nxt  = 1'b1;
        bit_nxt       = '0;
        last_word_nxt = (out_addr_r == LAST_ADDR);
        if (out_addr_r != LAST_ADDR)
        begin
          out_addr_nxt = out_addr_r + 1'b1;
        end
        dout_nxt      = fq.out_data[WORD_W-1];
      end
      if (enabled && sclk_rise && sh_valid_r)
      begin
        if (bit_r == BW'(WORD_W - 1))
        begin
          sh_valid_nxt = 1'b0;
          if (last_word_r)
          begin
            casc_n_nxt = 1'b0;
            phase_nxt  = scr_pkg::SCR_DONE;
          end
        end
        else
        begin
          bit_nxt  = bit_r + 1'b1;
          sh_nxt   = {sh_r[WORD_W-2:0], 1'b0};
          dout_nxt = sh_r[WORD_W-2];
        end
      end
    end

    // standby and finished memory leave the pin floating
    doe_nxt = enabled && casc_n_nxt &&
              (sh_valid_nxt || sh_valid_r) &&
              (phase_nxt == scr_pkg::SCR_STREAM);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      phase_r      <= scr_pkg::SCR_POWER_UP;
      por_r        <= '0;
      fetch_r      <= scr_pkg::ADDR_RESET;
      out_addr_r   <= scr_pkg::ADDR_RESET;
      fetch_done_r <= 1'b0;
      rd_pend_r    <= 1'b0;
      sh_r         <= '0;
      bit_r        <= '0;
      sh_valid_r   <= 1'b0;
      last_word_r  <= 1'b0;
      dout_r       <= 1'b0;
      doe_r        <= 1'b0;
      casc_n_r     <= 1'b1;
      rdy_oe_r     <= 1'b1;
      master_r     <= 1'b0;
      prog_r       <= 1'b0;
      in_reset_d_r <= 1'b0;
    end
    else if (ce)
    begin
      phase_r      <= phase_nxt;
      por_r        <= por_nxt;
      fetch_r      <= fetch_nxt;
      out_addr_r   <= out_addr_nxt;
      fetch_done_r <= fetch_done_nxt;
      rd_pend_r    <= rd_pend_nxt;
      sh_r         <= sh_nxt;
      bit_r        <= bit_nxt;
      sh_valid_r   <= sh_valid_nxt;
      last_word_r  <= last_word_nxt;
      dout_r       <= dout_nxt;
      doe_r        <= doe_nxt;
      casc_n_r     <= casc_n_nxt;
      rdy_oe_r     <= rdy_oe_nxt;
      master_r     <= master_nxt;
      prog_r       <= prog_nxt;
      in_reset_d_r <= in_reset_d_nxt;
    end
  end

  // ------------------------------------------------------------------
  // array read port, registered
  // ------------------------------------------------------------------
  logic [ADDR_W-1:0] maddr_r;
  logic              mrd_r;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      maddr_r <= scr_pkg::ADDR_RESET;
      mrd_r   <= 1'b0;
      vld_r   <= 1'b0;
    end
    else if (ce)
    begin
      maddr_r <= rd_pend_nxt ? fetch_r : maddr_r;
      mrd_r   <= rd_pend_nxt;
      // array word stands the cycle after the strobe
      vld_r   <= mrd_r && !clear;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign data_out            = dout_r;
  assign data_oe             = doe_r;
  assign chain_next_select_n = casc_n_r;
  assign ready_out           = 1'b0;
  assign ready_oe            = rdy_oe_r;
  assign mem_addr            = maddr_r;
  assign mem_rd              = mrd_r;
  assign program_mode        = prog_r;
  assign chain_master        = master_r;

endmodule : scr_readout

// file: verif/scr_readout_props.sv
/*
 * Pin-level checker for scr_readout, bound after the module.
 * Assumes ce low only in brief gaps and POR_CYCLES of at least 8.
 */
`timescale 1ns/1ns
module scr_readout_props #(
  parameter int POR_CYCLES = 20
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins
  input wire logic shift_clock,
  input wire logic reset_oe,
  input wire logic chip_select_n,
  input wire logic serial_program_enable_n,
  input wire logic reset_pol_high_en,
  // outputs
  input wire logic data_out,
  input wire logic data_oe,
  input wire logic chain_next_select_n,
  input wire logic ready_oe,
  input wire logic program_mode
);
  logic en_lvl;
  int   por_cnt_r;

  assign en_lvl = ~(reset_oe ^ reset_pol_high_en);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // cycles spent with ready pulled low
  always_ff @(posedge clk)
  begin
    if (!rst_b || !ready_oe)
      por_cnt_r <= 0;
    else
      por_cnt_r <= por_cnt_r + 1;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_RST_FLOAT:
    assert property ((!en_lvl)[*5] |-> !data_oe)
    else $error("data driven in pin reset");
  AST_RST_CASC:
    assert property ((!en_lvl)[*5] |-> chain_next_select_n)
    else $error("cascade low in pin reset");
  AST_STANDBY:
    assert property (chip_select_n[*5] |-> !data_oe)
    else $error("data driven while deselected");
  AST_PROG_STOP:
    assert property ((!serial_program_enable_n)[*5]
      |-> program_mode && !data_oe)
    else $error("read-out active in program mode");
  AST_CASC_FLOAT:
    assert property (!chain_next_select_n |-> !data_oe)
    else $error("data driven after last bit");
  AST_CASC_HOLD:
    assert property ((en_lvl && serial_program_enable_n)[*4] ##0
      !chain_next_select_n |=> !chain_next_select_n)
    else $error("cascade left its final state");
  AST_BIT_STEP:
    assert property (data_oe && $past(data_oe) && $past(data_oe, 2)
      && $changed(data_out) |-> $past(shift_clock, 3)
      || $past(shift_clock, 4) || $past(shift_clock, 5))
    else $error("bit moved without shift edge");
  AST_CS_ENABLE:
    assert property ($fell(chip_select_n) && en_lvl && !ready_oe
      && serial_program_enable_n && chain_next_select_n
      |-> ##[1:30] data_oe)
    else $error("no data drive after select");
  AST_POR_HOLD:
    assert property ($rose(rst_b) |-> ready_oe[*8])
    else $error("ready released early");
  AST_POR_END:
    assert property (por_cnt_r <= POR_CYCLES + 8)
    else $error("ready held too long");
  CVR_CASC: cover property ($fell(chain_next_select_n));
  CVR_DRIVE: cover property ($rose(data_oe));
  CVR_PROG: cover property ($rose(program_mode));
endmodule : scr_readout_props

bind scr_readout scr_readout_props #(.POR_CYCLES(POR_CYCLES)) props_i (
  .clk(clk), .rst_b(rst_b), .shift_clock(shift_clock),
  .reset_oe(reset_oe), .chip_select_n(chip_select_n),
  .serial_program_enable_n(serial_program_enable_n),
  .reset_pol_high_en(reset_pol_high_en), .data_out(data_out),
  .data_oe(data_oe), .chain_next_select_n(chain_next_select_n),
  .ready_oe(ready_oe), .program_mode(program_mode)
);

// file: verif/scr_host_model.sv
/*
 * Master-side model: makes the shift clock and shifts in the data pin.
 * Assumes the bench resolves the data pin level.
 */
`timescale 1ns/1ns
module scr_host_model
(
  // link clock out
  output logic      shift_clock,
  // serial data in
  input  wire logic data_pin
);
  logic [31:0] got;

  initial
  begin
    shift_clock = 1'b0;
    got = 32'h0;
  end

  // n rising edges at 160 ns, clock stands low between frames
  task automatic run(input int n);
    #3;
    for (int i = 0; i < n; i++)
    begin
      #80;
      got = {got[30:0], data_pin};
      shift_clock = 1'b1;
      #80;
      shift_clock = 1'b0;
    end
  endtask : run
endmodule : scr_host_model

// file: verif/tb.sv
/*
 * Self-checking bench for scr_readout: random array words, both reset
 * polarities, deselect, programming mode and a mid-run power-up.
 * Assumes LAST_ADDR 3 and POR_CYCLES 20 to keep the run short.
 */
`timescale 1ns/1ns
module tb;
  logic                       clk;
  logic                       rst_b;
  logic                       ce;
  logic                       shift_clock;
  logic                       reset_oe;
  logic                       chip_select_n;
  logic                       serial_program_enable_n;
  logic                       reset_pol_high_en;
  logic                       data_pin;
  logic                       data_out;
  logic                       data_oe;
  logic                       chain_next_select_n;
  logic                       ready_oe;
  logic [scr_pkg::ADDR_W-1:0] mem_addr;
  logic                       mem_rd;
  logic [scr_pkg::WORD_W-1:0] mem_data;
  logic                       program_mode;
  logic                       chain_master;
  logic                       flip_r;
  logic                       jitter_on;
  logic [7:0]                 arr [4];
  int                         bad_count;
  int                         total_checks;

  scr_readout #(.POR_CYCLES(20), .LAST_ADDR(12'h003)) scr_readout_i (
    .clk(clk), .rst_b(rst_b), .ce(ce), .shift_clock(shift_clock),
    .reset_oe(reset_oe), .chip_select_n(chip_select_n),
    .serial_program_enable_n(serial_program_enable_n),
    .reset_pol_high_en(reset_pol_high_en), .data_in(data_pin),
    .data_out(data_out), .data_oe(data_oe),
    .chain_next_select_n(chain_next_select_n), .ready_out(),
    .ready_oe(ready_oe), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_data(mem_data), .program_mode(program_mode),
    .chain_master(chain_master));
  scr_host_model host_i (.shift_clock(shift_clock), .data_pin(data_pin));

  // released pin toggles so a floating bit never reads as valid
  assign data_pin = data_oe ? data_out : flip_r;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // clock enable, randomly dropped while jitter is on
  always @(posedge clk)
  begin
    if (jitter_on)
      ce <= ($urandom_range(3) != 0);
    else
      ce <= 1'b1;
  end

  // stored array, word one cycle after the read strobe
  always @(posedge clk)
  begin
    flip_r <= ~flip_r;
    if (mem_rd)
      mem_data <= arr[mem_addr[1:0]];
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic pin_reset(input logic cs);
    @(posedge clk);
    reset_oe <= ~reset_pol_high_en;
    chip_select_n <= cs;
    cyc(6);
    reset_oe <= reset_pol_high_en;
    cyc(12);
    @(negedge clk);
  endtask : pin_reset

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // about 20 us of traffic expected
  initial
  begin
    #200000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    int n;
    rst_b = 1'b0;
    jitter_on = 1'b0;
    reset_oe = 1'b1;
    chip_select_n = 1'b1;
    serial_program_enable_n = 1'b1;
    reset_pol_high_en = 1'b1;
    flip_r = 1'b0;
    mem_data = '0;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(65));
    cyc(12);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(ready_oe, 1'b1, "ready held");
    cyc(40);
    @(negedge clk);
    chk(ready_oe, 1'b0, "ready released");
    chk(chain_next_select_n, 1'b1, "cascade idle");
    $display("test power_up done");
    for (int p = 1; p >= 0; p--)
    begin
      @(posedge clk);
      reset_pol_high_en <= p[0];
      foreach (arr[i]) arr[i] = 8'($urandom);
      pin_reset(1'b0);
      chk(chain_master, 1'b1, "master");
      chk(data_oe, 1'b1, "driving");
      host_i.run(32);
      chk(host_i.got, {arr[0], arr[1], arr[2], arr[3]}, "stream");
      host_i.run(1);
      chk(chain_next_select_n, 1'b0, "cascade");
      chk(data_oe, 1'b0, "float at end");
      host_i.run(3);
      chk(chain_next_select_n, 1'b0, "parked");
      $display("test stream done");
    end
    n = 1 + $urandom_range(20);
    pin_reset(1'b0);
    host_i.run(n);
    pin_reset(1'b1);
    chk(chain_master, 1'b0, "follower");
    chk(data_oe, 1'b0, "float deselected");
    chk(chain_next_select_n, 1'b1, "cascade cleared");
    host_i.run(4);
    chk(data_oe, 1'b0, "standby");
    @(posedge clk);
    chip_select_n <= 1'b0;
    jitter_on = 1'b1;
    cyc(12);
    jitter_on = 1'b0;
    cyc(2);
    host_i.run(8);
    chk(host_i.got[7:0], arr[0], "restart");
    $display("test deselect done");
    @(posedge clk);
    serial_program_enable_n <= 1'b0;
    cyc(8);
    @(negedge clk);
    chk(program_mode, 1'b1, "program mode");
    chk(data_oe, 1'b0, "no read-out");
    @(posedge clk);
    serial_program_enable_n <= 1'b1;
    cyc(6);
    @(negedge clk);
    chk(program_mode, 1'b0, "read-out mode");
    $display("test program done");
    pin_reset(1'b0);
    host_i.run(5);
    @(posedge clk);
    rst_b <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(data_oe, 1'b0, "float in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(40);
    host_i.run(8);
    chk(host_i.got[7:0], arr[0], "power-up clear");
    $display("test power_cycle done");
    end_sim();
  end
endmodule : tb
